// ===== dv/ccr_top_sva.sv
`timescale 1ns/10ps
`include "ccr_map.svh"

//////////////////////////////////////////////////////////////////////////////
// Port-level checker for the clock task registers
module ccr_top_sva
	import ccr_pkg::*;
#(
	parameter int CAL_IVL_W = 7  // Interval width
)
(
	// Clock and reset
	input wire logic          clk_sys_in,
	input wire logic          rst_in,
	// Register port
	input wire logic [11:0]   reg_addr_in,
	input wire logic [31:0]   reg_wdata_in,
	input wire logic          reg_wr_in,
	input wire logic          reg_rd_in,
	input wire logic [31:0]   reg_rdata_out,
	// Oscillator side and interrupt
	input wire ccr_osc_stat_s osc_stat_in,
	input wire ccr_osc_req_s  osc_req_out,
	input wire logic          irq_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);

	// Task write with trigger bit set
	sequence s_task(logic [11:0] a);
		reg_wr_in && reg_addr_in == a && reg_wdata_in[0];
	endsequence
	// Task write followed by an idle bus cycle
	sequence s_task_idle(logic [11:0] a);
		s_task(a) ##1 !reg_wr_in;
	endsequence

	property p_hf_start;
		s_task(`CCR_OFF_HF_START) |-> ##[1:2] (osc_req_out.hf_xtal_req && osc_req_out.hf_clk_req);
	endproperty
	property p_hf_stop;
		s_task_idle(`CCR_OFF_HF_STOP) |-> ##[0:1] !osc_req_out.hf_xtal_req;
	endproperty
	property p_cal_start;
		s_task(`CCR_OFF_CAL) |-> ##[1:2] (osc_req_out.cal_req && osc_req_out.hf_clk_req);
	endproperty
	property p_cal_done;
		osc_req_out.cal_req && osc_stat_in.cal_done |-> ##[1:2] !osc_req_out.cal_req;
	endproperty
	property p_lf_start;
		s_task(`CCR_OFF_LF_START) |-> ##[1:2] osc_req_out.lf_run_req;
	endproperty
	property p_lf_stop;
		s_task_idle(`CCR_OFF_LF_STOP) |-> ##[0:1] !osc_req_out.lf_run_req;
	endproperty
	property p_zero_write;
		reg_wr_in && reg_addr_in == `CCR_OFF_HF_START && !reg_wdata_in[0] && !osc_req_out.hf_xtal_req
			##1 !reg_wr_in |-> ##[0:1] !osc_req_out.hf_xtal_req;
	endproperty
	property p_task_read;
		reg_rd_in && reg_addr_in <= `CCR_OFF_CT_STOP |=> reg_rdata_out == 32'h0;
	endproperty

	a_hf_start: assert property (p_hf_start) else $error("crystal not requested");
	a_hf_stop: assert property (p_hf_stop) else $error("crystal not released");
	a_cal_start: assert property (p_cal_start) else $error("calibration not started");
	a_cal_done: assert property (p_cal_done) else $error("calibration not ended");
	a_lf_start: assert property (p_lf_start) else $error("low clock not started");
	a_lf_stop: assert property (p_lf_stop) else $error("low clock not stopped");
	a_zero_write: assert property (p_zero_write) else $error("zero write acted");
	a_task_read: assert property (p_task_read) else $error("task read not zero");
endmodule : ccr_top_sva

// ===== dv/testbench.sv
`timescale 1ns/10ps
`include "ccr_map.svh"

//////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the clock task registers
module testbench
	import ccr_pkg::*;
;
	// Row: task write and expected requests
	typedef struct {logic [11:0] a; logic [31:0] d; ccr_osc_req_s r;} ccr_tb_row_s;

	logic          clk_sys_in;
	logic          rst_in;
	logic [11:0]   reg_addr_in;
	logic [31:0]   reg_wdata_in;
	logic          reg_wr_in;
	logic          reg_rd_in;
	logic [31:0]   reg_rdata_out;
	ccr_osc_stat_s osc_stat_in;
	ccr_osc_req_s  osc_req_out;
	logic          irq_out;
	int            n_errors;
	int            n_compared;
	int            k;
	ccr_tb_row_s   rows [9] = '{'{12'h000, 32'h0, 6'h00}, '{12'h000, 32'h1, 6'h30}, '{12'h000, 32'h0, 6'h30},
		'{12'h004, 32'h0, 6'h30}, '{12'h004, 32'h1, 6'h00}, '{12'h000, 32'h1, 6'h30},
		'{12'h008, 32'h1, 6'h38}, '{12'h00c, 32'h0, 6'h38}, '{12'h00c, 32'h1, 6'h30}};

	ccr_top dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .osc_stat_in(osc_stat_in), .osc_req_out(osc_req_out), .irq_out(irq_out));

	//////////////////////////////////////////////////////////////////////////
	// Compare, bus tasks and verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
			n_errors++;
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge clk_sys_in);
		reg_wr_in <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge clk_sys_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge clk_sys_in);
		reg_rd_in <= 1'b0;
		#1;
		chk(reg_rdata_out, e);
	endtask : rd
	task automatic settle;
		repeat (2) @(posedge clk_sys_in);
		#1;
	endtask : settle
	task automatic tick;
		@(posedge clk_sys_in);
		osc_stat_in.lf_tick <= 1'b1;
		@(posedge clk_sys_in);
		osc_stat_in.lf_tick <= 1'b0;
	endtask : tick
	task automatic finish_test;
		if (n_errors == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test

	// Free-running system clock
	initial
	begin
		clk_sys_in = 1'b0;
		forever #20 clk_sys_in = ~clk_sys_in;
	end

	// Hang guard
	initial
	begin
		repeat (20000) @(posedge clk_sys_in);
		chk(32'h0, 32'h1);
		finish_test();
	end

	//////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		rst_in = 1'b1;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		reg_addr_in = 12'h000;
		reg_wdata_in = 32'h0;
		osc_stat_in = '{hf_xtal_ready: 1'b1, lf_rc_ready: 1'b1, default: 1'b0};
		n_errors = 0;
		n_compared = 0;
		repeat (16) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		#1;
		chk({25'h0, osc_req_out, irq_out}, 32'h0);
		rd(`CCR_OFF_LF_SNAP, 32'h0);
		// Table of task writes
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].d);
			settle();
			chk({26'h0, osc_req_out}, {26'h0, rows[i].r});
		end
		// Crystal source runs from RC until ready
		wr(`CCR_OFF_EV_LF, 32'h1);
		wr(`CCR_OFF_LF_SRC, 32'h1);
		wr(`CCR_OFF_LF_START, 32'h1);
		wr(`CCR_OFF_LF_SRC, 32'h2);
		settle();
		chk(osc_req_out.lf_osc_src, CCR_LF_RC);
		rd(`CCR_OFF_EV_LF, 32'h0);
		rd(`CCR_OFF_LF_SNAP, 32'h1);
		rd(`CCR_OFF_LF_SRC, 32'h1);
		wr(`CCR_OFF_IRQ_SET, 32'h2);
		settle();
		chk(irq_out, 1'b0);
		@(posedge clk_sys_in);
		osc_stat_in.lf_xtal_ready <= 1'b1;
		for (k = 0; k < 50 && osc_req_out.lf_osc_src !== CCR_LF_XTAL; k++)
			@(posedge clk_sys_in);
		if (k == 50)
		begin
			chk(32'h0, 32'h1);
			finish_test();
		end
		settle();
		chk(irq_out, 1'b1);
		rd(`CCR_OFF_EV_LF, 32'h1);
		wr(`CCR_OFF_IRQ_CLR, 32'h2);
		settle();
		chk(irq_out, 1'b0);
		wr(`CCR_OFF_IRQ_SET, 32'h2);
		wr(`CCR_OFF_EV_LF, 32'h1);
		settle();
		chk(irq_out, 1'b0);
		// Calibration with its completion
		wr(`CCR_OFF_CAL, 32'h1);
		settle();
		chk({26'h0, osc_req_out} & 32'h31, 32'h31);
		rd(`CCR_OFF_CAL, 32'h0);
		rd(12'h7fc, 32'h0);
		@(posedge clk_sys_in);
		osc_stat_in.cal_done <= 1'b1;
		@(posedge clk_sys_in);
		osc_stat_in.cal_done <= 1'b0;
		settle();
		chk(osc_req_out.cal_req, 1'b0);
		rd(`CCR_OFF_EV_DONE, 32'h1);
		// Status views, mask read-back and the high started event
		rd(`CCR_OFF_EV_HF, 32'h1);
		rd(`CCR_OFF_HF_RUN, 32'h1);
		rd(`CCR_OFF_HF_STAT, 32'h0001_0001);
		rd(`CCR_OFF_LF_RUN, 32'h1);
		rd(`CCR_OFF_LF_STAT, 32'h0001_0001);
		rd(`CCR_OFF_IRQ_CLR, 32'h2);
		// Calibration timer counts the interval down on low ticks
		wr(`CCR_OFF_CAL_IVL, 32'h3);
		rd(`CCR_OFF_CAL_IVL, 32'h3);
		wr(`CCR_OFF_CT_START, 32'h1);
		repeat (2) tick();
		rd(`CCR_OFF_EV_CTTO, 32'h0);
		tick();
		rd(`CCR_OFF_EV_CTTO, 32'h1);
		wr(`CCR_OFF_EV_CTTO, 32'h1);
		wr(`CCR_OFF_CT_START, 32'h1);
		wr(`CCR_OFF_CT_STOP, 32'h1);
		repeat (4) tick();
		rd(`CCR_OFF_EV_CTTO, 32'h0);
		// Back-to-back stop and start
		wr(`CCR_OFF_HF_STOP, 32'h1);
		wr(`CCR_OFF_HF_START, 32'h1);
		settle();
		chk(osc_req_out.hf_xtal_req, 1'b1);
		wr(`CCR_OFF_HF_STOP, 32'h1);
		settle();
		chk(osc_req_out.hf_xtal_req, 1'b0);
		// Reset in mid-run
		@(posedge clk_sys_in);
		rst_in <= 1'b1;
		repeat (2) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		#1;
		chk({25'h0, osc_req_out, irq_out}, 32'h0);
		rd(`CCR_OFF_EV_DONE, 32'h0);
		rd(`CCR_OFF_LF_SNAP, 32'h0);
		finish_test();
	end
endmodule : testbench

bind ccr_top ccr_top_sva #(.CAL_IVL_W(CAL_IVL_W)) u_sva (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
	.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out), .osc_stat_in(osc_stat_in), .osc_req_out(osc_req_out), .irq_out(irq_out));

// ===== hdl/ccr_top.sv
// Local design decision: the plain strobed port.
`timescale 1ns/10ps
`include "ccr_map.svh"

//////////////////////////////////////////////////////////////////////////////////////////////
// Functional notes
// R1 - Writing one at 0x000 starts high crystal
// R2 - Writing one at 0x004 stops high crystal
// R3 - Writing one at 0x010 starts RC calibration
// R4 - Low start snapshots source select into 0x41C
// R5 - Crystal source runs from RC until ready
// R6 - Low stop task halts low frequency clock
// R7 - Calibration borrows high clock, raises done
// R8 - Task registers stateless, zero writes ignored
module ccr_top
	import ccr_pkg::*;
#(
	parameter int CAL_IVL_W = `CCR_CAL_IVL_DEF_W  // Calibration interval width
)
(
	// Clock and reset
	input  wire logic                   clk_sys_in,
	input  wire logic                   rst_in,
	// Register port
	input  wire logic [`CCR_ADDR_W-1:0] reg_addr_in,
	input  wire logic [31:0]            reg_wdata_in,
	input  wire logic                   reg_wr_in,
	input  wire logic                   reg_rd_in,
	output logic      [31:0]            reg_rdata_out,
	// Oscillator side
	input  wire ccr_osc_stat_s          osc_stat_in,
	output ccr_osc_req_s                osc_req_out,
	// Interrupt
	output logic                        irq_out
);

	//////////////////////////////////////////////////////////////////////////////////////////
	// Parameter check
	// Refused at elaboration: counter and read-back slice need 1 to 16 bits
	if (CAL_IVL_W < 1 || CAL_IVL_W > `CCR_CAL_IVL_MAX_W)
	begin : g_bad_width
		$error("ccr_top: CAL_IVL_W must be 1 to 16");
	end

	//////////////////////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		logic [31:0]         rdata;       // Read data, one cycle after strobe
		ccr_osc_req_s        req;         // Oscillator requests
		logic                irq;         // Interrupt level
		logic                hf_run;      // High start task seen
		logic                lf_run;      // Low start task seen
		ccr_lf_sel_s         lf_sel;      // Source select
		ccr_lf_sel_s         lf_snap;     // Source snapshot
		logic                lf_started;  // Start event already raised
		ccr_cal_state_e      cal_st;      // Calibration sequencer
		logic                ct_on;       // Calibration timer counting
		logic [CAL_IVL_W-1:0] ct_cnt;     // Calibration timer count
		logic [CAL_IVL_W-1:0] cal_ivl;    // Calibration interval
		logic                hf_started;  // High start event already raised
		logic [`CCR_INT_W-1:0] ev;        // Sticky events
		logic [`CCR_INT_W-1:0] mask;      // Interrupt enables
	} ccr_state_s;

	ccr_state_s s_q;  // Registered state
	ccr_state_s s_d;  // Next state

	// Write strobes per task, with trigger bit set
	logic trig;
	logic wr_hf_start;
	logic wr_hf_stop;
	logic wr_lf_start;
	logic wr_lf_stop;
	logic wr_cal;
	logic wr_ct_start;
	logic wr_ct_stop;
	// Live status views
	logic        hf_xtal_on;   // High clock runs from crystal
	logic        lf_on;        // Low clock running
	ccr_lf_src_e lf_eff_src;   // Source actually in use
	logic        lf_sel_rdy;   // Selected source ready
	logic [`CCR_INT_W-1:0] ev_set;  // Event pulses this cycle

	//////////////////////////////////////////////////////////////////////////////////////////
	// Task decode, zero writes do nothing
	always_comb
	begin
		trig        = reg_wr_in && reg_wdata_in[`CCR_BIT_TRIGGER];                  // R8
		wr_hf_start = trig && (reg_addr_in == `CCR_OFF_HF_START);
		wr_hf_stop  = trig && (reg_addr_in == `CCR_OFF_HF_STOP);
		wr_lf_start = trig && (reg_addr_in == `CCR_OFF_LF_START);
		wr_lf_stop  = trig && (reg_addr_in == `CCR_OFF_LF_STOP);
		wr_cal      = trig && (reg_addr_in == `CCR_OFF_CAL);
		wr_ct_start = trig && (reg_addr_in == `CCR_OFF_CT_START);
		wr_ct_stop  = trig && (reg_addr_in == `CCR_OFF_CT_STOP);
	end

	//////////////////////////////////////////////////////////////////////////////////////////
	// Status views of the oscillators
	always_comb
	begin
		hf_xtal_on = s_q.req.hf_xtal_req && osc_stat_in.hf_xtal_ready;
		// Crystal not ready yet: fall back to RC
		case (s_q.lf_snap.src)
			CCR_LF_XTAL:
			begin
				lf_sel_rdy = osc_stat_in.lf_xtal_ready;
				lf_eff_src = lf_sel_rdy ? CCR_LF_XTAL : CCR_LF_RC;            // R5
			end
			CCR_LF_SYNTH:
			begin
				lf_sel_rdy = osc_stat_in.lf_synth_ready;
				lf_eff_src = CCR_LF_SYNTH;
			end
			default:
			begin
				lf_sel_rdy = osc_stat_in.lf_rc_ready;
				lf_eff_src = CCR_LF_RC;
			end
		endcase
		lf_on = s_q.lf_run && (lf_sel_rdy || osc_stat_in.lf_rc_ready);
	end

	//////////////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		s_d    = s_q;
		ev_set = `CCR_INT_RESET;

		// High crystal start and stop
		if (wr_hf_start)
		begin
			s_d.hf_run          = 1'b1;                                              // R1
			s_d.req.hf_xtal_req = 1'b1;                                              // R1
		end
		else if (wr_hf_stop)
		begin
			s_d.hf_run          = 1'b0;                                              // R2
			s_d.req.hf_xtal_req = 1'b0;                                              // R2
		end
		// Started event once per start, on the first ready cycle
		if (wr_hf_start || wr_hf_stop)
			s_d.hf_started = 1'b0;
		else if (s_q.req.hf_xtal_req && osc_stat_in.hf_xtal_ready && !s_q.hf_started)
		begin
			s_d.hf_started          = 1'b1;
			ev_set[`CCR_BIT_INT_HF] = 1'b1;
		end

		// Low clock start and stop
		if (wr_lf_start)
		begin
			s_d.lf_run     = 1'b1;
			s_d.lf_snap    = s_q.lf_sel;                                             // R4
			s_d.lf_started = 1'b0;
		end
		else if (wr_lf_stop)
		begin
			s_d.lf_run     = 1'b0;                                                   // R6
			s_d.lf_started = 1'b0;
		end
		// Event once the selected source itself runs
		if (s_q.lf_run && !s_q.lf_started && lf_sel_rdy && !wr_lf_stop)
		begin
			s_d.lf_started          = 1'b1;                                          // R5
			ev_set[`CCR_BIT_INT_LF] = 1'b1;
		end
		s_d.req.lf_run_req = s_d.lf_run;
		s_d.req.lf_osc_src = (s_d.lf_run && s_d.lf_snap.src == CCR_LF_XTAL && !osc_stat_in.lf_xtal_ready)
			? CCR_LF_RC : s_d.lf_snap.src;                                           // R5

		// Calibration sequencer
		case (s_q.cal_st)
			CCR_CAL_IDLE:
			begin
				if (wr_cal)
					s_d.cal_st = CCR_CAL_RUN;                                        // R3
			end
			CCR_CAL_RUN:
			begin
				if (osc_stat_in.cal_done)
				begin
					s_d.cal_st                = CCR_CAL_IDLE;                        // R7
					ev_set[`CCR_BIT_INT_DONE] = 1'b1;                                // R7
				end
			end
			default:
				s_d.cal_st = CCR_CAL_IDLE;
		endcase
		s_d.req.cal_req    = (s_d.cal_st == CCR_CAL_RUN);
		// High clock borrowed as reference while calibrating
		s_d.req.hf_clk_req = s_d.req.hf_xtal_req || s_d.req.cal_req;                 // R7

		// Calibration timer, counts down on low clock ticks
		if (wr_ct_start)
		begin
			s_d.ct_on  = 1'b1;
			s_d.ct_cnt = s_q.cal_ivl;
		end
		else if (wr_ct_stop)
			s_d.ct_on = 1'b0;
		else if (s_q.ct_on && osc_stat_in.lf_tick)
		begin
			if (s_q.ct_cnt <= CAL_IVL_W'(1))
			begin
				s_d.ct_on                 = 1'b0;
				s_d.ct_cnt                = '0;
				ev_set[`CCR_BIT_INT_CTTO] = 1'b1;
			end
			else
				s_d.ct_cnt = s_q.ct_cnt - CAL_IVL_W'(1);
		end

		// Register writes, events cleared by writing one
		if (reg_wr_in)
		begin
			if (reg_addr_in == `CCR_OFF_EV_HF)
				s_d.ev[`CCR_BIT_INT_HF] = s_q.ev[`CCR_BIT_INT_HF] & ~reg_wdata_in[`CCR_BIT_EVENT];
			else if (reg_addr_in == `CCR_OFF_EV_LF)
				s_d.ev[`CCR_BIT_INT_LF] = s_q.ev[`CCR_BIT_INT_LF] & ~reg_wdata_in[`CCR_BIT_EVENT];
			else if (reg_addr_in == `CCR_OFF_EV_DONE)
				s_d.ev[`CCR_BIT_INT_DONE] = s_q.ev[`CCR_BIT_INT_DONE] & ~reg_wdata_in[`CCR_BIT_EVENT];
			else if (reg_addr_in == `CCR_OFF_EV_CTTO)
				s_d.ev[`CCR_BIT_INT_CTTO] = s_q.ev[`CCR_BIT_INT_CTTO] & ~reg_wdata_in[`CCR_BIT_EVENT];
			else if (reg_addr_in == `CCR_OFF_IRQ_SET)
				s_d.mask = s_q.mask | reg_wdata_in[`CCR_INT_W-1:0];
			else if (reg_addr_in == `CCR_OFF_IRQ_CLR)
				s_d.mask = s_q.mask & ~reg_wdata_in[`CCR_INT_W-1:0];
			else if (reg_addr_in == `CCR_OFF_LF_SRC && !s_q.lf_run)
			begin
				// Source frozen while the low clock runs
				s_d.lf_sel.src      = ccr_lf_src_e'(reg_wdata_in[1:0]);
				s_d.lf_sel.bypass   = reg_wdata_in[`CCR_BIT_SRC_BYPASS];
				s_d.lf_sel.external = reg_wdata_in[`CCR_BIT_SRC_EXTERNAL];
			end
			else if (reg_addr_in == `CCR_OFF_CAL_IVL)
				s_d.cal_ivl = reg_wdata_in[CAL_IVL_W-1:0];
		end
		// Set wins over a clear in the same cycle
		s_d.ev  = s_d.ev | ev_set;
		s_d.irq = |(s_d.ev & s_d.mask);

		// Read data, task registers read as zero
		s_d.rdata = `CCR_WORD_ZERO;                                                  // R8
		if (reg_rd_in)
		begin
			if (reg_addr_in == `CCR_OFF_EV_HF)
				s_d.rdata[`CCR_BIT_EVENT] = s_q.ev[`CCR_BIT_INT_HF];
			else if (reg_addr_in == `CCR_OFF_EV_LF)
				s_d.rdata[`CCR_BIT_EVENT] = s_q.ev[`CCR_BIT_INT_LF];
			else if (reg_addr_in == `CCR_OFF_EV_DONE)
				s_d.rdata[`CCR_BIT_EVENT] = s_q.ev[`CCR_BIT_INT_DONE];
			else if (reg_addr_in == `CCR_OFF_EV_CTTO)
				s_d.rdata[`CCR_BIT_EVENT] = s_q.ev[`CCR_BIT_INT_CTTO];
			else if (reg_addr_in == `CCR_OFF_IRQ_SET || reg_addr_in == `CCR_OFF_IRQ_CLR)
				s_d.rdata[`CCR_INT_W-1:0] = s_q.mask;
			else if (reg_addr_in == `CCR_OFF_HF_RUN)
				s_d.rdata[`CCR_BIT_TRIGGER] = s_q.hf_run;
			else if (reg_addr_in == `CCR_OFF_HF_STAT)
			begin
				s_d.rdata[`CCR_BIT_STAT_SRC] = hf_xtal_on;
				s_d.rdata[`CCR_BIT_STAT_RUN] = hf_xtal_on || s_q.req.cal_req;
			end
			else if (reg_addr_in == `CCR_OFF_LF_RUN)
				s_d.rdata[`CCR_BIT_TRIGGER] = s_q.lf_run;
			else if (reg_addr_in == `CCR_OFF_LF_STAT)
			begin
				s_d.rdata[1:0]               = lf_eff_src;
				s_d.rdata[`CCR_BIT_STAT_RUN] = lf_on;
			end
			else if (reg_addr_in == `CCR_OFF_LF_SNAP)
			begin
				s_d.rdata[1:0]                   = s_q.lf_snap.src;                  // R4
				s_d.rdata[`CCR_BIT_SRC_BYPASS]   = s_q.lf_snap.bypass;
				s_d.rdata[`CCR_BIT_SRC_EXTERNAL] = s_q.lf_snap.external;
			end
			else if (reg_addr_in == `CCR_OFF_LF_SRC)
			begin
				s_d.rdata[1:0]                   = s_q.lf_sel.src;
				s_d.rdata[`CCR_BIT_SRC_BYPASS]   = s_q.lf_sel.bypass;
				s_d.rdata[`CCR_BIT_SRC_EXTERNAL] = s_q.lf_sel.external;
			end
			else if (reg_addr_in == `CCR_OFF_CAL_IVL)
				s_d.rdata[CAL_IVL_W-1:0] = s_q.cal_ivl;
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	//////////////////////////////////////////////////////////////////////////////////////////
	// Outputs straight from flops
	assign reg_rdata_out = s_q.rdata;
	assign osc_req_out   = s_q.req;
	assign irq_out       = s_q.irq;

endmodule : ccr_top

// ===== include/ccr_map.svh
`ifndef CCR_MAP_SVH
`define CCR_MAP_SVH

// Register offsets, byte addresses
`define CCR_ADDR_W           12
`define CCR_OFF_HF_START     12'h000
`define CCR_OFF_HF_STOP      12'h004
`define CCR_OFF_LF_START     12'h008
`define CCR_OFF_LF_STOP      12'h00c
`define CCR_OFF_CAL          12'h010
`define CCR_OFF_CT_START     12'h014
`define CCR_OFF_CT_STOP      12'h018
`define CCR_OFF_EV_HF        12'h100
`define CCR_OFF_EV_LF        12'h104
`define CCR_OFF_EV_DONE      12'h10c
`define CCR_OFF_EV_CTTO      12'h110
`define CCR_OFF_IRQ_SET      12'h304
`define CCR_OFF_IRQ_CLR      12'h308
`define CCR_OFF_HF_RUN       12'h408
`define CCR_OFF_HF_STAT      12'h40c
`define CCR_OFF_LF_RUN       12'h414
`define CCR_OFF_LF_STAT      12'h418
`define CCR_OFF_LF_SNAP      12'h41c
`define CCR_OFF_LF_SRC       12'h518
`define CCR_OFF_CAL_IVL      12'h538

// Field positions
`define CCR_BIT_TRIGGER      0
`define CCR_BIT_EVENT        0
`define CCR_BIT_STAT_SRC     0
`define CCR_BIT_STAT_RUN     16
`define CCR_BIT_SRC_BYPASS   16
`define CCR_BIT_SRC_EXTERNAL 17
`define CCR_BIT_INT_HF       0
`define CCR_BIT_INT_LF       1
`define CCR_BIT_INT_DONE     3
`define CCR_BIT_INT_CTTO     4

// Interrupt layout and calibration interval widths, reset values
`define CCR_INT_W            5
`define CCR_INT_RESET        5'h00
`define CCR_CAL_IVL_DEF_W    7
`define CCR_CAL_IVL_MAX_W    16
`define CCR_CAL_IVL_RESET    7'h00
`define CCR_WORD_ZERO        32'h0000_0000

`endif

// ===== include/ccr_pkg.sv
package ccr_pkg;

	// Low frequency source encodings
	typedef enum logic [1:0] {
		CCR_LF_RC    = 2'b00,
		CCR_LF_XTAL  = 2'b01,
		CCR_LF_SYNTH = 2'b10
	} ccr_lf_src_e;

	// Calibration sequencer states
	typedef enum logic [0:0] {
		CCR_CAL_IDLE = 1'b0,
		CCR_CAL_RUN  = 1'b1
	} ccr_cal_state_e;

	// Low frequency source selection
	typedef struct packed {
		logic        external;
		logic        bypass;
		ccr_lf_src_e src;
	} ccr_lf_sel_s;

	// Oscillator requests toward the analog side
	typedef struct packed {
		logic        hf_xtal_req;
		logic        hf_clk_req;
		logic        lf_run_req;
		ccr_lf_src_e lf_osc_src;
		logic        cal_req;
	} ccr_osc_req_s;

	// Oscillator status from the analog side
	typedef struct packed {
		logic hf_xtal_ready;
		logic lf_rc_ready;
		logic lf_xtal_ready;
		logic lf_synth_ready;
		logic cal_done;
		logic lf_tick;
	} ccr_osc_stat_s;

endpackage : ccr_pkg
